// ===== common/rsb_defs.svh
// Register indices, field positions, reset values and timing counts
`ifndef RSB_DEFS_SVH
`define RSB_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define RSB_IDX_RESET_ID   16'h0000
`define RSB_IDX_PAD_CTRL   16'h0c20
`define RSB_IDX_GP_CFG     16'h0c21
`define RSB_IDX_MIC_CFG    16'h0c22
`define RSB_IDX_PWR_STS    16'h0c23
`define RSB_IDX_RAW_STS5   16'h0d23
`define RSB_IDX_SEQ_BASE   16'h3000
`define RSB_IDX_DSP_BASE   16'h4000

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RSB_BOOT_FLAG_BIT  8
`define RSB_PAD_REG_PD_BIT 15
`define RSB_PAD_RST_PU_BIT 1
`define RSB_GP_OE_LSB      8
`define RSB_GP_LVL_LSB     16
`define RSB_MIC_ADDR_PD_BIT 4
`define RSB_MIC_TRST_PD_BIT 5
`define RSB_STS_SLEEP_BIT  0
`define RSB_STS_REGEN_BIT  1
`define RSB_STS_IRQ_BIT    2
// Identity value is arbitrary, not a real part code
`define RSB_DEVICE_ID      16'h00a5
`define RSB_HTRANS_NONSEQ  2'b10

// ****************************************************************
// Timing
// ****************************************************************
`define RSB_CLK_MHZ        200
`define RSB_BOOT_TIME_NS   1000
`define RSB_BOOT_CYC ((`RSB_BOOT_TIME_NS * `RSB_CLK_MHZ + 999) / 1000)

`endif

// ===== common/rsb_pkg.sv
// Types shared by the reset, sleep and boot control block
package rsb_pkg;

	typedef enum logic [1:0] {
		RSB_BT_HOLD,
		RSB_BT_RUN,
		RSB_BT_DONE
	} rsb_boot_state_t;

endpackage

// ===== rtl/rsb_boot_timer.sv
// Boot sequence timer: runs after every core reset release
`include "rsb_defs.svh"

module rsb_boot_timer
	import rsb_pkg::*;
#(
	parameter int BOOT_CYC = `RSB_BOOT_CYC
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Control
	input  wire logic hold,
	output logic      done
);

	localparam int CW = $clog2(BOOT_CYC + 1);

	rsb_boot_state_t state_r;
	logic [CW-1:0]   cnt_r;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= RSB_BT_HOLD;
			cnt_r   <= '0;
		end else if (hold) begin
			state_r <= RSB_BT_HOLD;
			cnt_r   <= '0;
		end else begin
			case (state_r)
			RSB_BT_HOLD: begin
				state_r <= RSB_BT_RUN;
				cnt_r   <= CW'(BOOT_CYC - 1);
			end
			RSB_BT_RUN: begin
				if (cnt_r == '0)
					state_r <= RSB_BT_DONE;
				else
					cnt_r <= cnt_r - CW'(1);
			end
			RSB_BT_DONE: state_r <= RSB_BT_DONE;
			default:     state_r <= RSB_BT_HOLD;
			endcase
		end
	end

	// Flag low from the edge after any reset begins, high once boot ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			done <= 1'b0;
		else
			done <= !hold && (state_r == RSB_BT_DONE);
	end

endmodule // rsb_boot_timer

// ===== rtl/rsb_ctrl.sv
// Reset, sleep and boot control with an AHB-Lite register slave
`include "rsb_defs.svh"

module rsb_ctrl
	import rsb_pkg::*;
#(
	parameter int NGP      = 5,
	parameter int AO_GP    = 4,
	parameter int NMIC     = 3,
	parameter int MEM_AW   = 4,
	parameter int BOOT_CYC = `RSB_BOOT_CYC
) (
	// AHB-Lite slave
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Supply monitors and reset pins
	input  wire logic        analog_supply_ok,
	input  wire logic        io_supply_one_ok,
	input  wire logic        core_supply_ok,
	input  wire logic        hw_reset_n,
	input  wire logic        regulator_enable_pin,
	// Power and boot state
	output logic             core_regulator_en,
	output logic             sleeping,
	output logic             boot_complete_flag,
	output logic             irq_n,
	output logic             irq_oe_n,
	// Pad configuration
	output logic [NGP-1:0]   gp_pull_down,
	output logic [NGP-1:0]   gp_oe_n,
	output logic [NGP-1:0]   gp_out,
	output logic             reset_pin_pull_up,
	output logic             regulator_enable_pull_down,
	output logic             control_addr_select_pull_down,
	output logic             test_reset_pull_down,
	output logic [NMIC-1:0]  digital_mic_sel
);

	localparam int MEM_N = 1 << MEM_AW;

	// ****************************************************************
	// Reset sources
	// ****************************************************************
	logic sw_rst_r;
	logic por_cond;
	logic hw_rst;
	logic sleep_now;
	logic core_rst;
	logic ao_rst;

	assign por_cond  = !analog_supply_ok || !io_supply_one_ok;
	assign hw_rst    = !hw_reset_n;
	assign sleep_now = analog_supply_ok && io_supply_one_ok
		&& !core_supply_ok;
	// Sleep holds the core in reset but spares always-on state
	assign core_rst  = por_cond || hw_rst || sw_rst_r
		|| sleep_now;
	assign ao_rst    = por_cond || hw_rst || sw_rst_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sleeping <= 1'b0;
		else
			sleeping <= sleep_now;
	end

	// ****************************************************************
	// AHB-Lite address and data phases
	// ****************************************************************
	logic        dp_wr_r;
	logic [15:0] dp_idx_r;
	logic [15:0] ap_idx;
	logic        ap_go;
	logic        wr_ok;
	logic [31:0] rd_nxt;

	assign ap_idx    = haddr[17:2];
	assign ap_go     = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r  <= 1'b0;
			dp_idx_r <= 16'h0000;
		end else begin
			dp_wr_r  <= ap_go && hwrite;
			dp_idx_r <= ap_idx;
		end
	end

	// Writes before boot ends are dropped; reset register always works
	assign wr_ok = dp_wr_r && (boot_complete_flag
		|| dp_idx_r == `RSB_IDX_RESET_ID);

	// Any value written to address zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sw_rst_r <= 1'b0;
		else
			sw_rst_r <= wr_ok
				&& dp_idx_r == `RSB_IDX_RESET_ID;
	end

	// ****************************************************************
	// Boot and interrupt
	// ****************************************************************
	logic boot_prev_r;
	logic irq_clr;

	rsb_boot_timer #(
		.BOOT_CYC (BOOT_CYC)
	) u_boot (
		.hclk    (hclk),
		.hresetn (hresetn),
		.hold    (core_rst),
		.done    (boot_complete_flag)
	);

	assign irq_clr = wr_ok && dp_idx_r == `RSB_IDX_PWR_STS
		&& hwdata[`RSB_STS_IRQ_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			boot_prev_r <= 1'b0;
		else
			boot_prev_r <= boot_complete_flag;
	end

	// Set beats clear, so a completion never goes unseen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_n <= 1'b1;
		else if (core_rst)
			irq_n <= 1'b1;
		else if (boot_complete_flag && !boot_prev_r)
			irq_n <= 1'b0;
		else if (irq_clr)
			irq_n <= 1'b1;
	end

	assign irq_oe_n = 1'b0;

	// ****************************************************************
	// Core regulator
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			core_regulator_en <= 1'b0;
		else if (por_cond)
			core_regulator_en <= 1'b0;
		else if ((sw_rst_r || hw_rst) && !regulator_enable_pin)
			core_regulator_en <= 1'b0;
		else if (regulator_enable_pin)
			core_regulator_en <= 1'b1;
	end

	// ****************************************************************
	// Always-on pad control
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_pin_pull_up          <= 1'b1;
			regulator_enable_pull_down <= 1'b1;
		end else if (ao_rst) begin
			reset_pin_pull_up          <= 1'b1;
			regulator_enable_pull_down <= 1'b1;
		end else if (wr_ok && dp_idx_r == `RSB_IDX_PAD_CTRL) begin
			reset_pin_pull_up <= hwdata[`RSB_PAD_RST_PU_BIT];
			regulator_enable_pull_down <=
				hwdata[`RSB_PAD_REG_PD_BIT];
		end
	end

	// ****************************************************************
	// General-purpose pins, one always-on
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NGP; g++) begin : g_gp
			logic gp_rst;
			logic gp_wr;
			assign gp_rst = (g == AO_GP) ? ao_rst : core_rst;
			assign gp_wr  = wr_ok && dp_idx_r == `RSB_IDX_GP_CFG;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					gp_pull_down[g] <= 1'b1;
					gp_oe_n[g]      <= 1'b1;
					gp_out[g]       <= 1'b0;
				end else if (gp_rst) begin
					gp_pull_down[g] <= 1'b1;
					gp_oe_n[g]      <= 1'b1;
					gp_out[g]       <= 1'b0;
				end else if (gp_wr) begin
					gp_pull_down[g] <= hwdata[g];
					gp_oe_n[g]      <= !hwdata[`RSB_GP_OE_LSB + g];
					gp_out[g]       <= hwdata[`RSB_GP_LVL_LSB + g];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Core-domain pad control
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			digital_mic_sel               <= '0;
			control_addr_select_pull_down <= 1'b1;
			test_reset_pull_down          <= 1'b1;
		end else if (core_rst) begin
			digital_mic_sel               <= '0;
			control_addr_select_pull_down <= 1'b1;
			test_reset_pull_down          <= 1'b1;
		end else if (wr_ok && dp_idx_r == `RSB_IDX_MIC_CFG) begin
			digital_mic_sel <= hwdata[NMIC-1:0];
			control_addr_select_pull_down <=
				hwdata[`RSB_MIC_ADDR_PD_BIT];
			test_reset_pull_down <= hwdata[`RSB_MIC_TRST_PD_BIT];
		end
	end

	// ****************************************************************
	// Sequencer and DSP memories
	// ****************************************************************
	logic [15:0]       seq_mem [MEM_N];
	logic [15:0]       dsp_mem [MEM_N];
	logic [MEM_N-1:0]  seq_vld_r;
	logic [MEM_N-1:0]  dsp_vld_r;
	logic              seq_hit;
	logic              dsp_hit;
	logic [MEM_AW-1:0] wa;

	assign wa = dp_idx_r[MEM_AW-1:0];
	assign seq_hit = dp_idx_r[15:MEM_AW]
		== `RSB_IDX_SEQ_BASE >> MEM_AW;
	assign dsp_hit = dp_idx_r[15:MEM_AW]
		== `RSB_IDX_DSP_BASE >> MEM_AW;

	// Storage has no reset; valid bits mark what survived
	always_ff @(posedge hclk) begin
		if (wr_ok && seq_hit)
			seq_mem[wa] <= hwdata[15:0];
		if (wr_ok && dsp_hit)
			dsp_mem[wa] <= hwdata[15:0];
	end

	// Sequencer memory only lost on loss of analog or io supply
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			seq_vld_r <= '0;
		else if (por_cond)
			seq_vld_r <= '0;
		else if (wr_ok && seq_hit)
			seq_vld_r[wa] <= 1'b1;
	end

	// DSP memory needs the core supply, so sleep wipes it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dsp_vld_r <= '0;
		else if (por_cond || sleep_now)
			dsp_vld_r <= '0;
		else if (wr_ok && dsp_hit)
			dsp_vld_r[wa] <= 1'b1;
	end

	// ****************************************************************
	// Read data, registered at the address phase
	// ****************************************************************
	logic [MEM_AW-1:0] ra;
	assign ra = ap_idx[MEM_AW-1:0];

	always_comb begin
		rd_nxt = 32'h00000000;
		if (ap_idx[15:MEM_AW] == `RSB_IDX_SEQ_BASE >> MEM_AW) begin
			if (seq_vld_r[ra])
				rd_nxt[15:0] = seq_mem[ra];
		end else if (ap_idx[15:MEM_AW]
			== `RSB_IDX_DSP_BASE >> MEM_AW) begin
			if (dsp_vld_r[ra])
				rd_nxt[15:0] = dsp_mem[ra];
		end else begin
			case (ap_idx)
			`RSB_IDX_RESET_ID: rd_nxt[15:0] = `RSB_DEVICE_ID;
			`RSB_IDX_PAD_CTRL: begin
				rd_nxt[`RSB_PAD_REG_PD_BIT] =
					regulator_enable_pull_down;
				rd_nxt[`RSB_PAD_RST_PU_BIT] = reset_pin_pull_up;
			end
			`RSB_IDX_GP_CFG: begin
				rd_nxt[NGP-1:0] = gp_pull_down;
				rd_nxt[`RSB_GP_OE_LSB +: NGP] = ~gp_oe_n;
				rd_nxt[`RSB_GP_LVL_LSB +: NGP] = gp_out;
			end
			`RSB_IDX_MIC_CFG: begin
				rd_nxt[NMIC-1:0] = digital_mic_sel;
				rd_nxt[`RSB_MIC_ADDR_PD_BIT] =
					control_addr_select_pull_down;
				rd_nxt[`RSB_MIC_TRST_PD_BIT] = test_reset_pull_down;
			end
			`RSB_IDX_PWR_STS: begin
				rd_nxt[`RSB_STS_SLEEP_BIT] = sleeping;
				rd_nxt[`RSB_STS_REGEN_BIT] = core_regulator_en;
				rd_nxt[`RSB_STS_IRQ_BIT]   = !irq_n;
			end
			`RSB_IDX_RAW_STS5:
				rd_nxt[`RSB_BOOT_FLAG_BIT] = boot_complete_flag;
			default: rd_nxt = 32'h00000000;
			endcase
		end
	end

	// Sampled a cycle early, so a read right after a write sees old data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (ap_go && !hwrite)
			hrdata <= rd_nxt;
	end

endmodule // rsb_ctrl

// ===== testbench/rsb_ctrl_checker.sv
// Port-level assertions for the reset, sleep and boot control block
module rsb_ctrl_checker
	import rsb_pkg::*;
#(
	parameter int NGP   = 5,
	parameter int AO_GP = 4,
	parameter int NMIC  = 3
) (
	// Bus
	input wire logic            hclk,
	input wire logic            hresetn,
	input wire logic            hsel,
	input wire logic [31:0]     haddr,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic            hready,
	input wire logic [31:0]     hrdata,
	// Supplies and pins
	input wire logic            analog_supply_ok,
	input wire logic            io_supply_one_ok,
	input wire logic            core_supply_ok,
	input wire logic            hw_reset_n,
	input wire logic            regulator_enable_pin,
	// State and pads
	input wire logic            core_regulator_en,
	input wire logic            sleeping,
	input wire logic            boot_complete_flag,
	input wire logic            irq_n,
	input wire logic            irq_oe_n,
	input wire logic [NGP-1:0]  gp_pull_down,
	input wire logic [NGP-1:0]  gp_oe_n,
	input wire logic            reset_pin_pull_up,
	input wire logic            regulator_enable_pull_down,
	input wire logic            control_addr_select_pull_down,
	input wire logic            test_reset_pull_down,
	input wire logic [NMIC-1:0] digital_mic_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic run_ok;
	assign run_ok = analog_supply_ok && io_supply_one_ok && core_supply_ok &&
		hw_reset_n && !sleeping;
	// ****************
	// Sequences
	// ****************
	sequence s_take(logic w, logic [15:0] idx);
		hsel && hready && htrans[1] && hwrite == w && haddr[17:2] == idx;
	endsequence
	// Eight quiet cycles of boot with nothing holding it in reset
	sequence s_boot_run;
		(!boot_complete_flag && run_ok) [*8];
	endsequence
	// ****************
	// Properties
	// ****************
	property p_sleep;
		analog_supply_ok && io_supply_one_ok && !core_supply_ok |=> sleeping;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep");
	property p_sleep_core;
		sleeping |=> !boot_complete_flag;
	endproperty
	a_sleep_core: assert property (p_sleep_core) else $error("core up");
	property p_sleep_pins;
		sleeping |=> gp_oe_n[0] && $stable(gp_oe_n[AO_GP]);
	endproperty
	a_sleep_pins: assert property (p_sleep_pins) else $error("pins");
	property p_pad_dflt;
		!hw_reset_n |=> &gp_pull_down && &gp_oe_n && reset_pin_pull_up &&
			regulator_enable_pull_down && control_addr_select_pull_down &&
			test_reset_pull_down && !irq_oe_n && digital_mic_sel == '0;
	endproperty
	a_pad_dflt: assert property (p_pad_dflt) else $error("pads");
	property p_swr;
		s_take(1'b1, 16'h0000) |-> ##[2:4] !boot_complete_flag;
	endproperty
	a_swr: assert property (p_swr) else $error("no soft reset");
	property p_boot_set;
		s_boot_run |-> ##[1:4] boot_complete_flag;
	endproperty
	a_boot_set: assert property (p_boot_set) else $error("boot late");
	property p_boot_min;
		$rose(hw_reset_n) |-> !boot_complete_flag [*7];
	endproperty
	a_boot_min: assert property (p_boot_min) else $error("boot early");
	property p_irq;
		$rose(boot_complete_flag) |=> $fell(irq_n);
	endproperty
	a_irq: assert property (p_irq) else $error("no irq edge");
	property p_raw;
		s_take(1'b0, 16'h0d23) |=> hrdata[8] == $past(boot_complete_flag);
	endproperty
	a_raw: assert property (p_raw) else $error("raw bit");
	property p_reg_off;
		!hw_reset_n && !regulator_enable_pin |=> !core_regulator_en;
	endproperty
	a_reg_off: assert property (p_reg_off) else $error("regulator on");
endmodule // rsb_ctrl_checker

bind rsb_ctrl rsb_ctrl_checker #(.NGP(NGP), .AO_GP(AO_GP), .NMIC(NMIC))
	rsb_ctrl_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .analog_supply_ok, .io_supply_one_ok, .core_supply_ok,
	.hw_reset_n, .regulator_enable_pin, .core_regulator_en, .sleeping,
	.boot_complete_flag, .irq_n, .irq_oe_n, .gp_pull_down, .gp_oe_n,
	.reset_pin_pull_up, .regulator_enable_pull_down,
	.control_addr_select_pull_down, .test_reset_pull_down, .digital_mic_sel);

// ===== testbench/rsb_host_model.sv
// Host model: register bus master and regulator enable pin driver
module rsb_host_model #(
	parameter int WAKE_CYC = 300000
) (
	// Bus
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        boot_complete_flag,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	// Pin
	output logic             regulator_enable_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		regulator_enable_pin = 1'b1;
	end
	// ****************
	// Transfers
	// ****************
	// One idle edge before each transfer keeps reads clear of write data
	task automatic xfer(input logic w, input logic [15:0] idx,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, idx, d, q);
	endtask
	task automatic wait_boot;
		int n;
		n = 0;
		while (boot_complete_flag !== 1'b1 && n < 1000) begin
			@(posedge hclk);
			n++;
		end
	endtask
	task automatic wake_wait;
		repeat (WAKE_CYC) @(posedge hclk);
	endtask
	task automatic init_seq;
		logic [15:0] ia [9];
		logic [15:0] da [9];
		ia = '{16'h0019, 16'h0081, 16'h02d4, 16'h035e, 16'h0443,
			16'h04b0, 16'h051b, 16'h055b, 16'h059b};
		da = '{16'h0001, 16'he022, 16'h0000, 16'h000c, 16'hdc1a,
			16'h0066, 16'h0001, 16'h0001, 16'h0001};
		for (int i = 0; i < 9; i++) begin
			wr(ia[i], {16'h0, da[i]});
		end
	endtask
	task automatic sw_reset(input logic keep);
		@(posedge hclk);
		regulator_enable_pin <= keep;
		wr(16'h0000, 32'h0);
		// Flag drops at the first edge after the write returns; waiting avoids a stale boot flag
		repeat (2) @(posedge hclk);
	endtask
endmodule // rsb_host_model

// ===== testbench/testbench.sv
// Self-checking bench for the reset, sleep and boot control block
`include "rsb_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, ana, io, core, hwrn;
	logic        reg_pin, reg_en, slp, flag, irq_n, irq_oe_n, rst_pu;
	logic        regen_pd, addr_pd, trst_pd, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize, mic_sel;
	logic [4:0]  gp_pd, gp_oe_n, gp_out;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc = 0;
	rsb_ctrl #(.BOOT_CYC(8)) rsb_ctrl_i (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .analog_supply_ok(ana), .io_supply_one_ok(io),
		.core_supply_ok(core), .hw_reset_n(hwrn), .regulator_enable_pin(reg_pin),
		.core_regulator_en(reg_en), .sleeping(slp), .boot_complete_flag(flag),
		.irq_n, .irq_oe_n, .gp_pull_down(gp_pd), .gp_oe_n, .gp_out,
		.reset_pin_pull_up(rst_pu), .regulator_enable_pull_down(regen_pd),
		.control_addr_select_pull_down(addr_pd),
		.test_reset_pull_down(trst_pd), .digital_mic_sel(mic_sel));
	rsb_host_model #(.WAKE_CYC(20)) rsb_host_model_i (.hclk,
		.hready(hreadyout), .hrdata, .boot_complete_flag(flag), .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .regulator_enable_pin(reg_pin));
	// ****************
	// Helpers
	// ****************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [15:0] idx);
		rsb_host_model_i.xfer(1'b0, idx, 32'h0, q);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_por;
		chk({gp_pd, gp_oe_n, mic_sel}, {5'h1f, 5'h1f, 3'h0});
		chk({rst_pu, regen_pd, addr_pd, trst_pd, irq_oe_n, irq_n, flag},
			7'b1111010);
		chk(hresp, 1'b0);
		rsb_host_model_i.wait_boot();
		#1 chk({irq_n, flag}, 2'b01);
		rd(`RSB_IDX_RAW_STS5);
		chk(q & 32'h100, 32'h100);
		rsb_host_model_i.wr(`RSB_IDX_PWR_STS, 32'h4);
		rd(`RSB_IDX_PWR_STS);
		chk(q, 32'h2);
		chk(irq_n, 1'b1);
		$display("t_por done");
	endtask
	task automatic t_init;
		rsb_host_model_i.init_seq();
		rd(16'h0019);
		chk(q, 32'h0);
		chk(flag, 1'b1);
		$display("t_init done");
	endtask
	task automatic t_sleep;
		rsb_host_model_i.wr(`RSB_IDX_GP_CFG, 32'h0011_1100);
		rsb_host_model_i.wr(`RSB_IDX_SEQ_BASE + 16'h1, 32'ha1);
		rsb_host_model_i.wr(`RSB_IDX_DSP_BASE + 16'h1, 32'hb2);
		core <= 1'b0;
		repeat (3) @(posedge hclk);
		#1 chk({slp, flag, gp_oe_n}, {2'b10, 5'h0f});
		chk(gp_out, 5'h10);
		@(posedge hclk);
		core <= 1'b1;
		rsb_host_model_i.wake_wait();
		rsb_host_model_i.wait_boot();
		rd(`RSB_IDX_SEQ_BASE + 16'h1);
		chk(q, 32'ha1);
		rd(`RSB_IDX_DSP_BASE + 16'h1);
		chk(q, 32'h0);
		chk({slp, gp_oe_n}, {1'b0, 5'h0f});
		$display("t_sleep done");
	endtask
	task automatic t_swrst;
		rsb_host_model_i.wr(`RSB_IDX_SEQ_BASE, 32'h1234);
		rsb_host_model_i.wr(`RSB_IDX_DSP_BASE, 32'h5678);
		rsb_host_model_i.sw_reset(1'b1);
		rd(`RSB_IDX_RAW_STS5);
		chk(q & 32'h100, 32'h0);
		rsb_host_model_i.wait_boot();
		rd(`RSB_IDX_SEQ_BASE);
		chk(q, 32'h1234);
		chk({gp_oe_n, reg_en}, {5'h1f, 1'b1});
		rd(`RSB_IDX_DSP_BASE);
		chk(q, 32'h5678);
		rsb_host_model_i.sw_reset(1'b0);
		rsb_host_model_i.wait_boot();
		chk(reg_en, 1'b0);
		$display("t_swrst done");
	endtask
	task automatic t_hwrst;
		rsb_host_model_i.wr(`RSB_IDX_GP_CFG, 32'h0011_1100);
		hwrn <= 1'b0;
		repeat (2) @(posedge hclk);
		#1 chk({gp_oe_n, gp_pd, flag}, {5'h1f, 5'h1f, 1'b0});
		@(posedge hclk);
		hwrn <= 1'b1;
		rsb_host_model_i.wait_boot();
		chk(flag, 1'b1);
		$display("t_hwrst done");
	endtask
	// ****************
	// Run
	// ****************
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Whole run needs well under two thousand cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		hresetn = 1'b0;
		{ana, io, core, hwrn} = 4'hf;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1 t_por();
		t_init();
		t_sleep();
		t_swrst();
		t_hwrst();
		print_verdict();
	end
endmodule // testbench
